// File: hdl/trip_reset_params.svh
// constants for the feeder trip and reset control block
`ifndef TRIP_RESET_PARAMS_SVH
`define TRIP_RESET_PARAMS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define REG_SW_OFF 12'h000
`define REG_BANK_OFF 12'h004
`define REG_CMD_OFF 12'h008
`define REG_STATUS_OFF 12'h00c
`define REG_BF_DELAY_OFF 12'h010
`define REG_OUT_CFG_OFF 12'h014

// ****************************************************************
// field positions
// ****************************************************************
// function_switch_group_one bit 4 (index 3): breaker failure enable
`define FSG1_BF_EN_BIT 3
// function_switch_group_two bit 6 (index 5): backup high-set disable
`define FSG2_BACKUP_DIS_BIT 5
// function_switch_group_two bit routing trip direction to a relay
`define FSG2_DIR_ROUTE_BIT 7
// blocking switch bits 6/7/8 (index 5/6/7)
`define BSG_IND_BIT 5
`define BSG_UNLATCH_BIT 6
`define BSG_ERASE_BIT 7
// command register bits (bits 0 to 2 pulse on a written one; bit 3 is the bank value)
`define CMD_UNLATCH_BIT 0
`define CMD_UNLATCH_ERASE_BIT 1
`define CMD_BANK_SEL_BIT 2
`define CMD_BANK_VAL_BIT 3

// ****************************************************************
// reset values and timing
// ****************************************************************
`define SW_RESET 32'h0000_0000
`define BF_DELAY_RESET 16'h0001
// memory hold limit of directional stages, in ms
`define MEM_HOLD_MS 2500
`define CLK_MHZ 10
`define MEM_HOLD_CYC (`MEM_HOLD_MS * 1000 * `CLK_MHZ)
// flash half period of setting indicators, in ms
`define FLASH_HALF_MS 250
`define FLASH_HALF_CYC (`FLASH_HALF_MS * 1000 * `CLK_MHZ)

`endif

// File: hdl/trip_reset_pkg.sv
// types for the feeder trip and reset control block
package trip_reset_pkg;
  typedef enum logic [1:0] {bf_idle, bf_timing, bf_fired} bf_state_t;
  typedef enum logic [0:0] {bank_main, bank_second} bank_t;
endpackage

// File: hdl/sync2.sv
// two flip-flop synchroniser for a vector of pins
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_t;
  sync_state_t st_ff;
  sync_state_t nxt_st;

  // meta stage is read only by the sync stage
  always_comb begin
    nxt_st.meta = din;
    nxt_st.sync = st_ff.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.sync;
endmodule
`default_nettype wire

// File: hdl/delay_timer.sv
// restartable down counter that reports expiry of a programmed delay
`timescale 1ns/1ps
`default_nettype none
module delay_timer #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic [WIDTH-1:0] load,
  output logic expired
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic active;
  } tmr_state_t;
  tmr_state_t st_ff;
  tmr_state_t nxt_st;

  // counting starts when run rises; dropping run cancels at once
  always_comb begin
    nxt_st = st_ff;
    if (!run) begin
      nxt_st.active = 1'b0;
      nxt_st.cnt = load;
    end else if (!st_ff.active) begin
      nxt_st.active = 1'b1;
    end else if (st_ff.cnt != '0) begin
      nxt_st.cnt = st_ff.cnt - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign expired = run && st_ff.active && (st_ff.cnt == '0);
endmodule
`default_nettype wire

// File: hdl/feeder_trip_reset_control.sv
// trip logic, reset matrix and setting bank selection of a feeder relay module
//
// Contract
// - backup high-set start blocks inverse-time low-set
// - above backup threshold, backup operate time applies
// - switch group two bit disables backup stage
// - long-time directional stages stop tripping once voltage memory runs out
// - direction output needs low-set, direction, both sectors
// - direction reaches relay only when routed
// - backup trip after delay if fault persists
// - breaker failure enabled by switch, delay from setting
// - latched trip output holds until unlatch
// - five unlatch sources: buttons, serial, external
// - program button, first serial command keep records
// - both buttons, second command, external erase records
// - reset button clears indicators only
// - blocking switch bits pick external reset level
// - two banks, exactly one active
// - serial command selects active bank
// - external inputs also select bank
// - menu value 0 main, 1 second
// - external selection locks out serial and panel
// - second bank active flashes setting indicators
// - both banks reachable from serial and panel
`timescale 1ns/1ps
`default_nettype none
`include "trip_reset_params.svh"
module feeder_trip_reset_control #(
  parameter int MEM_HOLD_CYCLES = `MEM_HOLD_CYC,
  parameter int FLASH_HALF_CYCLES = `FLASH_HALF_CYC,
  parameter int BF_SCALE = 1000
) (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // stage starts and operates from the measuring logic
  input wire logic low_start,
  input wire logic low_operate,
  input wire logic low_inverse_mode,
  input wire logic low_dir_ok,
  input wire logic [1:0] phase_in_sector,
  input wire logic high_operate,
  input wire logic backup_start,
  input wire logic backup_operate,
  input wire logic voltage_lost,
  input wire logic dir_time_long,
  // panel buttons and external pins (asynchronous)
  input wire logic btn_reset,
  input wire logic btn_program,
  input wire logic display_dark,
  input wire logic ext_control_in_a,
  input wire logic ext_control_in_b,
  input wire logic ext_control_in_c,
  // outputs
  output logic main_trip_output,
  output logic backup_trip_output,
  output logic trip_dir_relay,
  output logic low_blocked,
  output logic backup_stage_enabled,
  output logic bank_second_active,
  output logic setting_leds_flash,
  output logic clear_indicators,
  output logic erase_records
);
  import trip_reset_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0] fsg1;
    logic [7:0] fsg2;
    logic [7:0] bsg;
    logic [15:0] bf_delay;
    logic latch_en;
    logic menu_bank;
    bank_t bank;
    bf_state_t bf;
    logic main_latch;
    logic backup_latch;
    logic [31:0] flash_cnt;
    logic flash;
    logic clr_ind;
    logic erase;
    logic [2:0] ext_prev;
    logic btn_prev;
    logic [31:0] prdata;
    logic [31:0] mem_cnt;
  } ctl_state_t;
  ctl_state_t st_ff;
  ctl_state_t nxt_st;

  logic [2:0] ext_sync;
  logic [1:0] btn_sync;
  logic bf_expired;
  logic [31:0] bf_load;
  logic wr_en;
  logic rd_en;
  logic low_eff;
  logic dir_trip_ok;
  logic trip_cause;
  logic ext_any;
  logic ext_rise;
  logic btn_both_rise;
  logic btn_prog_rise;
  logic unlatch;
  logic erase_req;
  logic ind_req;
  logic cmd_unl;
  logic cmd_unl_erase;
  logic cmd_bank;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  sync2 #(.WIDTH(3)) u_ext_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({ext_control_in_c, ext_control_in_b, ext_control_in_a}),
    .dout(ext_sync)
  );

  sync2 #(.WIDTH(2)) u_btn_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({btn_program, btn_reset}),
    .dout(btn_sync)
  );

  // ****************************************************************
  // apb decode
  // ****************************************************************
  // zero wait state slave; read data loads in the setup cycle so it stands through the access phase
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_mapped(paddr);

  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == `REG_SW_OFF) || (a == `REG_BANK_OFF) || (a == `REG_CMD_OFF) ||
      (a == `REG_STATUS_OFF) || (a == `REG_BF_DELAY_OFF) || (a == `REG_OUT_CFG_OFF);
  endfunction

  // serial command pulses from the command register
  assign cmd_unl = wr_en && (paddr == `REG_CMD_OFF) && pwdata[`CMD_UNLATCH_BIT];
  assign cmd_unl_erase = wr_en && (paddr == `REG_CMD_OFF) && pwdata[`CMD_UNLATCH_ERASE_BIT];
  assign cmd_bank = wr_en && (paddr == `REG_CMD_OFF) && pwdata[`CMD_BANK_SEL_BIT];

  // ****************************************************************
  // protection decisions
  // ****************************************************************
  // backup stage disabled by switch acts as infinite threshold
  assign backup_stage_enabled = !st_ff.fsg2[`FSG2_BACKUP_DIS_BIT];
  // inverse-time low-set blocked while backup stage has started
  assign low_blocked = backup_stage_enabled && backup_start && low_inverse_mode;
  // long-time directional stages lose their trip once memory hold has run out
  assign dir_trip_ok = !(dir_time_long && voltage_lost && (st_ff.mem_cnt >= MEM_HOLD_CYCLES));
  assign low_eff = low_operate && !low_blocked && dir_trip_ok;
  assign trip_cause = low_eff || (high_operate && dir_trip_ok) ||
    (backup_stage_enabled && backup_operate);
  // direction output needs operate, right direction and both phases in sector
  assign trip_dir_relay = st_ff.fsg2[`FSG2_DIR_ROUTE_BIT] && low_eff && low_dir_ok &&
    (&phase_in_sector);

  // ****************************************************************
  // reset matrix
  // ****************************************************************
  assign ext_any = |ext_sync;
  assign ext_rise = |(ext_sync & ~st_ff.ext_prev);
  assign btn_both_rise = (&btn_sync) && !st_ff.btn_prev;
  assign btn_prog_rise = btn_sync[1] && !btn_sync[0] && !st_ff.btn_prev && display_dark;
  // five unlatch routes
  assign unlatch = btn_prog_rise || btn_both_rise || cmd_unl || cmd_unl_erase ||
    (ext_rise && (st_ff.bsg[`BSG_UNLATCH_BIT] || st_ff.bsg[`BSG_ERASE_BIT]));
  // only the erasing routes clear the records
  assign erase_req = btn_both_rise || cmd_unl_erase || (ext_rise && st_ff.bsg[`BSG_ERASE_BIT]);
  assign ind_req = unlatch || (btn_sync[0] && !btn_sync[1]) ||
    (ext_rise && st_ff.bsg[`BSG_IND_BIT]);

  // breaker failure delay in cycles, scaled from the menu value
  assign bf_load = 32'(st_ff.bf_delay) * 32'(BF_SCALE);

  delay_timer #(.WIDTH(32)) u_bf_timer (
    .pclk(pclk),
    .presetn(presetn),
    .run((st_ff.bf == bf_timing) && trip_cause),
    .load(bf_load),
    .expired(bf_expired)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ext_prev = ext_sync;
    nxt_st.btn_prev = &btn_sync || (btn_sync[1] && !btn_sync[0]);
    nxt_st.clr_ind = ind_req;
    nxt_st.erase = erase_req;
    // memory hold timer runs while voltage is lost
    if (!voltage_lost) begin
      nxt_st.mem_cnt = '0;
    end else if (st_ff.mem_cnt < MEM_HOLD_CYCLES) begin
      nxt_st.mem_cnt = st_ff.mem_cnt + 32'h0000_0001;
    end
    // register writes
    if (wr_en) begin
      if (paddr == `REG_SW_OFF) begin
        nxt_st.fsg1 = pwdata[7:0];
        nxt_st.fsg2 = pwdata[15:8];
        nxt_st.bsg = pwdata[23:16];
      end else if (paddr == `REG_BANK_OFF) begin
        if (!ext_any) begin
          nxt_st.menu_bank = pwdata[0];
        end
      end else if (paddr == `REG_BF_DELAY_OFF) begin
        nxt_st.bf_delay = pwdata[15:0];
      end else if (paddr == `REG_OUT_CFG_OFF) begin
        nxt_st.latch_en = pwdata[0];
      end
    end
    // bank selection: external inputs win and lock out the others
    if (ext_any) begin
      nxt_st.bank = bank_second;
    end else if (cmd_bank) begin
      nxt_st.bank = pwdata[`CMD_BANK_VAL_BIT] ? bank_second : bank_main;
      nxt_st.menu_bank = pwdata[`CMD_BANK_VAL_BIT];
    end else begin
      nxt_st.bank = nxt_st.menu_bank ? bank_second : bank_main;
    end
    // main trip latch; a new cause wins over an unlatch
    if (trip_cause && st_ff.latch_en) begin
      nxt_st.main_latch = 1'b1;
    end else if (unlatch || !st_ff.latch_en) begin
      nxt_st.main_latch = 1'b0;
    end
    // breaker failure sequence
    case (st_ff.bf)
      bf_idle: begin
        if (trip_cause && st_ff.fsg1[`FSG1_BF_EN_BIT]) begin
          nxt_st.bf = bf_timing;
        end
      end
      bf_timing: begin
        if (!trip_cause || !st_ff.fsg1[`FSG1_BF_EN_BIT]) begin
          nxt_st.bf = bf_idle;
        end else if (bf_expired) begin
          nxt_st.bf = bf_fired;
          nxt_st.backup_latch = st_ff.latch_en;
        end
      end
      default: begin
        if (!trip_cause) begin
          nxt_st.bf = bf_idle;
        end
      end
    endcase
    // a firing in this cycle, or a standing fired cause, wins over an unlatch
    if (unlatch && !(nxt_st.bf == bf_fired && trip_cause)) begin
      nxt_st.backup_latch = 1'b0;
    end
    // flash timer for setting indicators
    if (st_ff.bank != bank_second) begin
      nxt_st.flash_cnt = '0;
      nxt_st.flash = 1'b0;
    end else if (st_ff.flash_cnt >= FLASH_HALF_CYCLES - 1) begin
      nxt_st.flash_cnt = '0;
      nxt_st.flash = !st_ff.flash;
    end else begin
      nxt_st.flash_cnt = st_ff.flash_cnt + 32'h0000_0001;
    end
    // registered read data
    if (rd_en) begin
      if (paddr == `REG_SW_OFF) begin
        nxt_st.prdata = {8'h00, st_ff.bsg, st_ff.fsg2, st_ff.fsg1};
      end else if (paddr == `REG_BANK_OFF) begin
        nxt_st.prdata = {30'h0, st_ff.bank == bank_second, st_ff.menu_bank};
      end else if (paddr == `REG_STATUS_OFF) begin
        nxt_st.prdata = {24'h0, low_start, ext_any, low_blocked, trip_dir_relay, st_ff.bf == bf_fired,
          backup_trip_output, main_trip_output, st_ff.bank == bank_second};
      end else if (paddr == `REG_BF_DELAY_OFF) begin
        nxt_st.prdata = {16'h0, st_ff.bf_delay};
      end else if (paddr == `REG_OUT_CFG_OFF) begin
        nxt_st.prdata = {31'h0, st_ff.latch_en};
      end else begin
        nxt_st.prdata = 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.bf_delay <= `BF_DELAY_RESET;
      st_ff.bank <= bank_main;
      st_ff.bf <= bf_idle;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // unlatched mode follows the cause directly
  assign main_trip_output = st_ff.main_latch || trip_cause;
  assign backup_trip_output = st_ff.backup_latch || (st_ff.bf == bf_fired && trip_cause);
  assign bank_second_active = (st_ff.bank == bank_second);
  assign setting_leds_flash = st_ff.flash;
  assign clear_indicators = st_ff.clr_ind;
  assign erase_records = st_ff.erase;
  assign prdata = st_ff.prdata;
endmodule
`default_nettype wire

// File: verification/feeder_trip_reset_control_props.sv
// checker of trip, blocking and bank behaviour at the control block ports
`timescale 1ns/1ps
`default_nettype none
`include "trip_reset_params.svh"
module feeder_trip_reset_control_props #(
  parameter int FLASH_HALF_CYCLES = 4
) (
  // clock, reset and apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // stage inputs
  input wire logic low_operate,
  input wire logic low_inverse_mode,
  input wire logic low_dir_ok,
  input wire logic [1:0] phase_in_sector,
  input wire logic backup_start,
  input wire logic backup_operate,
  // outputs
  input wire logic main_trip_output,
  input wire logic backup_trip_output,
  input wire logic trip_dir_relay,
  input wire logic low_blocked,
  input wire logic backup_stage_enabled,
  input wire logic bank_second_active,
  input wire logic setting_leds_flash,
  input wire logic clear_indicators,
  input wire logic erase_records
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  int stay_ff;
  // run of an unchanged flash level; a counter because the half period is a parameter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stay_ff <= 0;
    else stay_ff <= (bank_second_active && $stable(setting_leds_flash)) ? stay_ff + 1 : 0;
  end
  sequence s_sw_write;
    psel && penable && pwrite && paddr == `REG_SW_OFF;
  endsequence
  property p_low_block;
    backup_start && low_inverse_mode && backup_stage_enabled |-> low_blocked;
  endproperty
  a_low_block: assert property (p_low_block) else $error("low stage not blocked");
  property p_low_free;
    !(backup_start && low_inverse_mode) |-> !low_blocked;
  endproperty
  a_low_free: assert property (p_low_free) else $error("low stage blocked");
  property p_backup_trip;
    backup_operate && backup_stage_enabled |-> main_trip_output;
  endproperty
  a_backup_trip: assert property (p_backup_trip) else $error("backup stage no trip");
  property p_backup_off;
    s_sw_write |=> backup_stage_enabled == !$past(pwdata[`FSG2_BACKUP_DIS_BIT + 8]);
  endproperty
  a_backup_off: assert property (p_backup_off) else $error("backup enable wrong");
  property p_dir;
    trip_dir_relay |-> low_operate && low_dir_ok && phase_in_sector == 2'h3;
  endproperty
  a_dir: assert property (p_dir) else $error("direction without cause");
  property p_bf_follows;
    $rose(backup_trip_output) |-> main_trip_output || $past(main_trip_output);
  endproperty
  a_bf_follows: assert property (p_bf_follows) else $error("backup trip alone");
  property p_flash;
    stay_ff <= FLASH_HALF_CYCLES + 1;
  endproperty
  a_flash: assert property (p_flash) else $error("indicators not flashing");
  property p_erase_clears;
    erase_records |-> clear_indicators;
  endproperty
  a_erase_clears: assert property (p_erase_clears) else $error("erase without clear");
endmodule
`default_nettype wire

// File: verification/breaker_model.sv
// feeder and breaker model: fault current flows until a trip coil opens a breaker
`timescale 1ns/1ps
`default_nettype none
module breaker_model #(
  parameter int OPEN_CYCLES = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // coils and fault control
  input wire logic main_coil,
  input wire logic backup_coil,
  input wire logic fault,
  input wire logic stuck,
  output logic current_on
);
  int cnt_ff;
  logic open_ff;
  // a stuck breaker ignores its coil; the upstream one on the backup coil always clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 0;
      open_ff <= 1'h0;
    end else if (!fault) begin
      cnt_ff <= 0;
      open_ff <= 1'h0;
    end else begin
      cnt_ff <= (main_coil && !stuck) ? cnt_ff + 1 : 0;
      open_ff <= open_ff || backup_coil || cnt_ff == OPEN_CYCLES;
    end
  end
  assign current_on = fault && !open_ff;
endmodule
`default_nettype wire

// File: verification/feeder_trip_reset_control_tb.sv
// self-checking bench of the feeder trip and reset control block
`timescale 1ns/1ps
`default_nettype none
`include "trip_reset_params.svh"
module feeder_trip_reset_control_tb;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, rd_err, current_on, low_start, backup_start, backup_operate;
  logic low_operate = 1'h0, low_inverse_mode = 1'h0, low_dir_ok = 1'h0, high_operate = 1'h0;
  logic [1:0] phase_in_sector = 2'h0;
  logic voltage_lost = 1'h0, dir_time_long = 1'h0, display_dark = 1'h1;
  logic btn_reset = 1'h0, btn_program = 1'h0, fault = 1'h0, stuck = 1'h0;
  logic ext_control_in_a = 1'h0, ext_control_in_b = 1'h0, ext_control_in_c = 1'h0;
  logic main_trip_output, backup_trip_output, trip_dir_relay, low_blocked, backup_stage_enabled;
  logic bank_second_active, setting_leds_flash, clear_indicators, erase_records;
  int fail_count = 0, compares = 0, cyc = 0, n_clr = 0, n_er = 0, n_bt = 0, n_fl = 0, c0, e0;
  // backup stage inputs follow the fault current seen through the breaker
  assign low_start = low_operate;
  assign backup_start = current_on;
  assign backup_operate = current_on;
  feeder_trip_reset_control #(.MEM_HOLD_CYCLES(50), .FLASH_HALF_CYCLES(4), .BF_SCALE(1))
    u_feeder_trip_reset_control (.*);
  breaker_model u_breaker_model (.pclk(pclk), .presetn(presetn), .main_coil(main_trip_output),
    .backup_coil(backup_trip_output), .fault(fault), .stuck(stuck), .current_on(current_on));
  always #50 pclk = ~pclk;
  // counting pulses keeps checks clear of the exact pulse cycle
  always @(negedge pclk) begin
    cyc++;
    if (clear_indicators === 1'h1) n_clr++;
    if (erase_records === 1'h1) n_er++;
    if (backup_trip_output === 1'h1) n_bt++;
    if (setting_leds_flash === 1'h1) n_fl++;
    if (cyc == 20000) begin
      fail_count++;
      final_report;
    end
  end
  task final_report;
    if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  // one apb transfer; read data and error are taken at the edge that completes the access
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd_err = pslverr;
    rdata = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task step(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, `REG_SW_OFF, 32'h0);
    chk(rdata, `SW_RESET, "switch reset");
    apb(1'h0, `REG_BF_DELAY_OFF, 32'h0);
    chk(rdata, `BF_DELAY_RESET, "delay reset");
    apb(1'h0, 12'hffc, 32'h0);
    chk(rd_err, 1'h1, "unmapped");
    // backup stage blocks an inverse low stage, then is switched off
    for (int k = 0; k < 2; k++) begin
      apb(1'h1, `REG_SW_OFF, k ? 32'h2000 : 32'h0);
      @(posedge pclk);
      low_inverse_mode <= 1'h1;
      fault <= 1'h1;
      step(1);
      chk(backup_stage_enabled, !k, "backup enable");
      chk(low_blocked, !k, "low block");
      chk(main_trip_output, !k, "backup trip");
      @(posedge pclk);
      fault <= 1'h0;
      low_inverse_mode <= 1'h0;
    end
    // direction output over sectors, direction flag and routing
    for (int k = 0; k < 6; k++) begin
      apb(1'h1, `REG_SW_OFF, k < 5 ? 32'h8000 : 32'h0);
      @(posedge pclk);
      low_operate <= 1'h1;
      low_dir_ok <= k != 4;
      phase_in_sector <= k[1:0] | {2{k > 3}};
      step(1);
      chk(trip_dir_relay, k == 3, "direction relay");
    end
    // each reset way against a latched trip; the last way must leave it latched
    @(posedge pclk);
    low_operate <= 1'h0;
    apb(1'h1, `REG_OUT_CFG_OFF, 32'h1);
    apb(1'h1, `REG_SW_OFF, 32'h80_0000);
    for (int w = 0; w < 6; w++) begin
      @(posedge pclk);
      fault <= 1'h1;
      @(posedge pclk);
      fault <= 1'h0;
      step(4);
      chk(main_trip_output, 1'h1, "latched trip");
      c0 = n_clr;
      e0 = n_er;
      if (w < 2) apb(1'h1, `REG_CMD_OFF, w + 1);
      else begin
        @(posedge pclk);
        btn_program <= w == 2 || w == 3;
        btn_reset <= w == 3 || w == 5;
        ext_control_in_c <= w == 4;
        repeat (4) @(posedge pclk);
        btn_program <= 1'h0;
        btn_reset <= 1'h0;
        ext_control_in_c <= 1'h0;
      end
      step(6);
      chk(main_trip_output, w == 5, "unlatch");
      chk(n_er != e0, w == 1 || w == 3 || w == 4, "erase");
      chk(n_clr != c0, 1'h1, "indicators");
    end
    apb(1'h1, `REG_CMD_OFF, 32'h1);
    // breaker failure: stuck breaker, healthy breaker, unit off
    apb(1'h1, `REG_OUT_CFG_OFF, 32'h0);
    apb(1'h1, `REG_BF_DELAY_OFF, 32'ha);
    for (int k = 0; k < 3; k++) begin
      apb(1'h1, `REG_SW_OFF, k < 2 ? 32'h8 : 32'h0);
      @(posedge pclk);
      stuck <= k != 1;
      fault <= 1'h1;
      c0 = n_bt;
      step(25);
      chk(n_bt != c0, k == 0, "breaker failure");
      @(posedge pclk);
      fault <= 1'h0;
      stuck <= 1'h0;
    end
    // long-time directional trip is lost once the voltage memory has run out
    @(posedge pclk);
    high_operate <= 1'h1;
    dir_time_long <= 1'h1;
    voltage_lost <= 1'h1;
    step(10);
    chk(main_trip_output, 1'h1, "memory held");
    step(50);
    chk(main_trip_output, 1'h0, "memory expired");
    @(posedge pclk);
    high_operate <= 1'h0;
    voltage_lost <= 1'h0;
    // bank by menu, serial command, and external pins with lockout
    apb(1'h1, `REG_BANK_OFF, 32'h1);
    apb(1'h0, `REG_BANK_OFF, 32'h0);
    chk(rdata[1], 1'h1, "menu second");
    c0 = n_fl;
    step(12);
    chk(n_fl != c0, 1'h1, "flash");
    apb(1'h1, `REG_BANK_OFF, 32'h0);
    step(1);
    chk(bank_second_active, 1'h0, "menu main");
    apb(1'h1, `REG_CMD_OFF, 32'hc);
    step(1);
    chk(bank_second_active, 1'h1, "serial second");
    apb(1'h1, `REG_CMD_OFF, 32'h4);
    step(1);
    chk(bank_second_active, 1'h0, "serial main");
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk);
      {ext_control_in_c, ext_control_in_b, ext_control_in_a} <= 3'h1 << k;
      step(5);
      chk(bank_second_active, 1'h1, "external second");
      apb(1'h1, `REG_CMD_OFF, 32'h4);
      apb(1'h1, `REG_BANK_OFF, 32'h1);
      step(1);
      chk(bank_second_active, 1'h1, "locked");
      @(posedge pclk);
      {ext_control_in_c, ext_control_in_b, ext_control_in_a} <= 3'h0;
      step(5);
      chk(bank_second_active, 1'h0, "menu kept");
    end
    final_report;
  end
endmodule
bind feeder_trip_reset_control feeder_trip_reset_control_props #(.FLASH_HALF_CYCLES(FLASH_HALF_CYCLES))
  u_feeder_trip_reset_control_props (.*);
`default_nettype wire
